// *** rtl/cdq_consts.svh ***
// Offsets, field positions, reset values and timing counts of the channel data block
`ifndef CDQ_CONSTS_SVH
`define CDQ_CONSTS_SVH
// ---------------------------------------------------------------
// Register byte offsets and per-channel register word selects
// ---------------------------------------------------------------
`define CDQ_A_CTRL 8'h00
`define CDQ_A_RPI 8'h04
`define CDQ_A_STAT 8'h08
`define CDQ_A_MASK 8'h0C
`define CDQ_A_RTS 8'h10
`define CDQ_A_TLO 8'h14
`define CDQ_A_THI 8'h18
`define CDQ_A_FLAGS 8'h1C
`define CDQ_A_CAL 8'h20
`define CDQ_A_CHBASE 8'h40
`define CDQ_CH_SIGLO 2'h0
`define CDQ_CH_SLOPE 2'h1
`define CDQ_CH_ENGLO 2'h2
`define CDQ_CH_DATA 2'h3
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CDQ_CTRL_OUTMODE 0
`define CDQ_CTRL_SYNCEN 1
`define CDQ_EV_FRAME 0
`define CDQ_EV_FAULT 1
`define CDQ_EV_CRC 2
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define CDQ_RPI_RST 16'h000A
`define CDQ_RTS_MAX 16'h7FFF
`define CDQ_SLOPE_ONE 32'h00010000
`define CDQ_SLOPE_CUR 32'h0000019A
`define CDQ_SIGLO_CUR 16'h0FA0
`define CDQ_MS_NS 1000000
`define CDQ_CLK_NS 8
`define CDQ_MS_CYCLES (`CDQ_MS_NS / `CDQ_CLK_NS)
`endif

// *** rtl/cdq_pkg.sv ***
// Types shared by the channel data block
package cdq_pkg;
    localparam int CDQ_NCH = 4;
    // One converter sample with its link check and condition bits
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [15:0] data;
        logic crc_ok;
        logic over;
        logic under;
        logic open_wire;
        logic shorted;
    } cdq_sample_t;
    // Module-level stamp sent with each transfer
    typedef struct packed {
        logic valid;
        logic [63:0] sys_time;
        logic [15:0] rts;
    } cdq_frame_t;
endpackage

// *** rtl/cdq_top.sv ***
// Channel data, timestamp and quality block with APB registers
// Summary of operation
// - Stamp each scan or output with system time
// - One module timestamp per input transfer
// - Align sample instants to sync pulse
// - Rolling millisecond counter, 0 to 32767
// - At interval scan, refresh data, capture stamp
// - Output mode stamps only at converter load
// - Channel values delivered as IEEE single floats
// - Interval programmable down to one millisecond
// - Linear signal to engineering unit scaling
// - Current channels default 4-20 mA to 0-100
// - Untrusted flag on range, open, short
// - Doubtful flag on calibration or offset problems
// - Bad CRC keeps last sample, flags doubtful
// - Faults on indicator and in status words
//
// The address map and the APB interface to the registers were left to the implementer.
`include "cdq_consts.svh"
module cdq_top
    import cdq_pkg::*;
#(
    parameter int MS_CYCLES = `CDQ_MS_CYCLES,
    parameter logic [3:0] CHAN_CURRENT = 4'h0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time base and converter side
    input wire logic [63:0] sys_time,
    input wire logic sync_pulse,
    input wire cdq_sample_t sample,
    input wire logic dac_load,
    // Controller side
    output logic scan_req,
    output cdq_frame_t frame,
    output logic fault_led,
    output logic irq
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [1:0] ctrl; // Output mode and sync enable
    logic [15:0] requested_packet_interval; // Requested packet interval in ms
    logic [2:0] stat; // Sticky events
    logic [2:0] mask; // Event enables
    logic [11:0] calcfg; // Calibrating, bad offset, uncalibrated
    logic [15:0] sig_lo [CDQ_NCH]; // Low signal point
    logic [31:0] slope [CDQ_NCH]; // Gain in Q16
    logic [31:0] eng_lo [CDQ_NCH]; // Low engineering point, Q16
    logic [31:0] hold [CDQ_NCH]; // Last valid scaled float
    logic [31:0] chan_out [CDQ_NCH]; // Published float
    logic [3:0] untr_live; // Untrusted conditions from last sample
    logic [3:0] crc_bad; // Last sample failed its check
    logic [3:0] untr_flag; // Published untrusted flags
    logic [3:0] doubt_flag; // Published doubtful flags
    logic [16:0] ms_cnt; // Millisecond divider
    logic ms_tick; // One-cycle millisecond pulse
    logic [15:0] rts; // Rolling timestamp
    logic [15:0] rpi_cnt; // Milliseconds since last scan
    logic scan_now; // Scan instant this cycle
    logic [2:0] ev; // Events this cycle
    logic [2:0] w1c; // Bits software clears
    logic wr_en; // Write takes effect this edge
    logic [31:0] rd_val; // Read mux
    logic [31:0] cur_float; // Scaled float of incoming sample

    // ---------------------------------------------------------------
    // Float conversion
    // ---------------------------------------------------------------
    // Signed Q16 to IEEE single; low bits are truncated, not rounded
    function automatic logic [31:0] q16_to_float(input logic [31:0] v);
        logic [31:0] mag;
        logic [31:0] norm;
        logic [7:0] msb;
        mag = v[31] ? (~v + 32'h00000001) : v;
        msb = 8'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                msb = 8'(i);
            end
        end
        norm = mag << (8'd31 - msb);
        if (mag == 32'h00000000) begin
            q16_to_float = 32'h00000000;
        end else begin
            q16_to_float = {v[31], 8'(msb + 8'd111), norm[30:8]};
        end
    endfunction

    // Linear scaling of the incoming sample
    always_comb begin
        logic [47:0] prod;
        logic [31:0] delta;
        prod = 48'h000000000000;
        delta = 32'(signed'({1'b0, sample.data}) - signed'({1'b0, sig_lo[sample.chan]}));
        prod = 48'(signed'(delta) * signed'(slope[sample.chan]));
        cur_float = q16_to_float(prod[47:16] + eng_lo[sample.chan]);
    end

    // ---------------------------------------------------------------
    // Time base
    // ---------------------------------------------------------------
    // Millisecond divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= 17'h00000;
            ms_tick <= 1'b0;
        end else if (ms_cnt == 17'(MS_CYCLES - 1)) begin
            ms_cnt <= 17'h00000;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 17'h00001;
            ms_tick <= 1'b0;
        end
    end

    // Rolling timestamp never stops, even while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts <= 16'h0000;
        end else if (ms_tick) begin
            rts <= (rts == `CDQ_RTS_MAX) ? 16'h0000 : rts + 16'h0001;
        end
    end

    // Interval counter; a zero interval is treated as one ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpi_cnt <= 16'h0000;
        end else if (ctrl[`CDQ_CTRL_SYNCEN] && sync_pulse) begin
            rpi_cnt <= 16'h0000;
        end else if (scan_now) begin
            rpi_cnt <= 16'h0000;
        end else if (ms_tick) begin
            rpi_cnt <= rpi_cnt + 16'h0001;
        end
    end

    // Scan fires on the tick that completes the interval, or on a sync pulse
    assign scan_now = !ctrl[`CDQ_CTRL_OUTMODE] &&
        ((ms_tick && (rpi_cnt + 16'h0001 >= requested_packet_interval)) ||
         (ctrl[`CDQ_CTRL_SYNCEN] && sync_pulse));

    // ---------------------------------------------------------------
    // Channel data path
    // ---------------------------------------------------------------
    // Sample intake; a failed check keeps the previous good value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CDQ_NCH; c++) begin
                hold[c] <= 32'h00000000;
            end
            untr_live <= 4'h0;
            crc_bad <= 4'h0;
        end else if (sample.valid) begin
            if (sample.crc_ok) begin
                hold[sample.chan] <= cur_float;
                crc_bad[sample.chan] <= 1'b0;
            end else begin
                crc_bad[sample.chan] <= 1'b1;
            end
            untr_live[sample.chan] <= sample.over | sample.under |
                sample.open_wire | sample.shorted;
        end
    end

    // Publish values, flags and stamps at the scan; only the stamp at converter load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CDQ_NCH; c++) begin
                chan_out[c] <= 32'h00000000;
            end
            untr_flag <= 4'h0;
            doubt_flag <= 4'h0;
            frame <= '0;
            scan_req <= 1'b0;
        end else begin
            scan_req <= scan_now;
            frame.valid <= 1'b0;
            if (scan_now) begin
                chan_out <= hold;
                untr_flag <= untr_live;
                doubt_flag <= crc_bad | calcfg[3:0] | calcfg[7:4] | calcfg[11:8];
                frame.valid <= 1'b1;
                frame.sys_time <= sys_time;
                frame.rts <= rts;
            end else if (ctrl[`CDQ_CTRL_OUTMODE] && dac_load) begin
                frame.valid <= 1'b1;
                frame.sys_time <= sys_time;
                frame.rts <= rts;
            end
        end
    end

    // Front indicator follows any published untrusted channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_led <= 1'b0;
        end else begin
            fault_led <= |untr_flag;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    assign ev = {sample.valid & ~sample.crc_ok, |untr_flag, frame.valid};
    assign w1c = (wr_en && paddr == `CDQ_A_STAT) ? pwdata[2:0] : 3'h0;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat <= 3'h0;
            irq <= 1'b0;
        end else begin
            stat <= (stat & ~w1c) | ev;
            irq <= |(((stat & ~w1c) | ev) & mask);
        end
    end

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign wr_en = psel && penable && pready && pwrite;

    // Handshake and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= (paddr[7:6] == 2'b00 && paddr > `CDQ_A_CAL) || paddr[1:0] != 2'b00;
            end
        end
    end

    // Read decode; unmapped words below the channel space read zero and answer with an error; words from 8'h80 up alias the channel registers
    always_comb begin
        rd_val = 32'h00000000;
        if (paddr[1:0] != 2'b00) begin
            rd_val = 32'h00000000; // Misaligned reads return zero, never an aliased word
        end else if (paddr >= `CDQ_A_CHBASE) begin
            case (paddr[3:2])
                `CDQ_CH_SIGLO: rd_val = {16'h0000, sig_lo[paddr[5:4]]};
                `CDQ_CH_SLOPE: rd_val = slope[paddr[5:4]];
                `CDQ_CH_ENGLO: rd_val = eng_lo[paddr[5:4]];
                default: rd_val = chan_out[paddr[5:4]];
            endcase
        end else begin
            case (paddr)
                `CDQ_A_CTRL: rd_val = {30'h00000000, ctrl};
                `CDQ_A_RPI: rd_val = {16'h0000, requested_packet_interval};
                `CDQ_A_STAT: rd_val = {29'h00000000, stat};
                `CDQ_A_MASK: rd_val = {29'h00000000, mask};
                `CDQ_A_RTS: rd_val = {16'h0000, frame.rts};
                `CDQ_A_TLO: rd_val = frame.sys_time[31:0];
                `CDQ_A_THI: rd_val = frame.sys_time[63:32];
                `CDQ_A_FLAGS: rd_val = {24'h000000, doubt_flag, untr_flag};
                `CDQ_A_CAL: rd_val = {20'h00000, calcfg};
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 2'h0;
            requested_packet_interval <= `CDQ_RPI_RST;
            mask <= 3'h0;
            calcfg <= 12'h000;
        end else if (wr_en) begin
            case (paddr)
                `CDQ_A_CTRL: ctrl <= pwdata[1:0];
                `CDQ_A_RPI: requested_packet_interval <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                `CDQ_A_MASK: mask <= pwdata[2:0];
                `CDQ_A_CAL: calcfg <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // Per-channel scaling; current channels reset to percent of span
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CDQ_NCH; c++) begin
                sig_lo[c] <= CHAN_CURRENT[c] ? `CDQ_SIGLO_CUR : 16'h0000;
                slope[c] <= CHAN_CURRENT[c] ? `CDQ_SLOPE_CUR : `CDQ_SLOPE_ONE;
                eng_lo[c] <= 32'h00000000;
            end
        end else if (wr_en && paddr >= `CDQ_A_CHBASE && paddr[1:0] == 2'b00) begin
            case (paddr[3:2])
                `CDQ_CH_SIGLO: sig_lo[paddr[5:4]] <= pwdata[15:0];
                `CDQ_CH_SLOPE: slope[paddr[5:4]] <= pwdata;
                `CDQ_CH_ENGLO: eng_lo[paddr[5:4]] <= pwdata;
                default: ;
            endcase
        end
    end
endmodule

// *** dv/cdq_monitor.sv ***
// Port checker for the channel data block, bound to its top
module cdq_monitor
    import cdq_pkg::*;
(
    // Clock and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Time base and controller side
    input wire logic [63:0] sys_time,
    input wire logic dac_load,
    input wire logic scan_req,
    input wire cdq_frame_t frame
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // -----------------------------------------------
    // Sequences
    // -----------------------------------------------
    // Access cycle still waiting for the slave
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Slave answers on the following edge
    sequence s_ans;
        ##1 pready;
    endsequence
    // -----------------------------------------------
    // Properties
    // -----------------------------------------------
    a_one_wait: assert property (s_wait |-> s_ans) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_scan_frame: assert property (scan_req |-> frame.valid)
        else $error("scan without frame");
    a_frame_single: assert property (frame.valid |=> !frame.valid)
        else $error("frame strobe held");
    a_stamp_time: assert property (frame.valid |-> frame.sys_time == $past(sys_time))
        else $error("frame time wrong");
    a_stamp_hold: assert property (!frame.valid |-> $stable(frame.rts)
        && $stable(frame.sys_time)) else $error("stamp moved");
    a_dac_only: assert property (frame.valid && !scan_req |-> $past(dac_load))
        else $error("output stamp without load");
    a_rts_range: assert property (frame.rts <= 16'h7FFF)
        else $error("rts out of range");
endmodule
bind cdq_top cdq_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .sys_time(sys_time),
    .dac_load(dac_load), .scan_req(scan_req), .frame(frame));

// *** dv/cdq_ctrl_model.sv ***
// Owning controller model: takes frames and derives update intervals
module cdq_ctrl_model
    import cdq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frames from the block
    input wire cdq_frame_t frame,
    // Derived view
    output logic [15:0] delta,
    output logic [31:0] count,
    output logic wrapped
);
    logic [15:0] prev; // Stamp of the previous frame
    // Interval is newest stamp minus the previous one, modulo the range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 16'h0000;
            delta <= 16'h0000;
            count <= 32'h0;
            wrapped <= 1'b0;
        end else if (frame.valid) begin
            prev <= frame.rts;
            delta <= (frame.rts - prev) & 16'h7FFF;
            count <= count + 32'h1;
            // Wrap noted only for the exact top-to-zero step
            if (prev == 16'h7FFF && frame.rts == 16'h0000) begin
                wrapped <= 1'b1;
            end
        end
    end
endmodule

// *** dv/cdq_tb_top.sv ***
// Self-checking bench for the channel data block
`include "cdq_consts.svh"
module cdq_tb_top
    import cdq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 2; // Short millisecond keeps the wrap within the run
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] prdata_cur; // Read data of the current-mode instance
    logic pready, pslverr, scan_req, fault_led, irq, wrapped;
    logic [63:0] sys_time = 64'h0;
    logic sync_pulse = 1'b0;
    logic dac_load = 1'b0;
    cdq_sample_t sample = '0;
    cdq_frame_t frame;
    logic [15:0] delta;
    logic [31:0] count;
    int errors = 0;
    int comparisons = 0;
    int seed = 32'h3C10;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cdq_note_t;
    cdq_note_t notes[$]; // Expected bus answers, oldest first
    always #4 pclk = ~pclk;
    always @(posedge pclk) sys_time <= sys_time + 64'h1;
    cdq_top #(.MS_CYCLES(MSC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_time(sys_time),
        .sync_pulse(sync_pulse), .sample(sample), .dac_load(dac_load),
        .scan_req(scan_req), .frame(frame), .fault_led(fault_led), .irq(irq));
    // Second instance with every channel in current mode, sharing the bus
    cdq_top #(.MS_CYCLES(MSC), .CHAN_CURRENT(4'hF)) dut_cur (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_cur), .pready(), .pslverr(), .sys_time(sys_time),
        .sync_pulse(sync_pulse), .sample(sample), .dac_load(dac_load),
        .scan_req(), .frame(), .fault_led(), .irq());
    cdq_ctrl_model u_ctrl (.pclk(pclk), .presetn(presetn), .frame(frame),
        .delta(delta), .count(count), .wrapped(wrapped));
    // -----------------------------------------------
    // Tasks
    // -----------------------------------------------
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic timeout;
        errors++;
        final_report();
    endtask
    // One APB transfer; the answer is judged by the watcher below
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] ed, input logic [31:0] m, input logic e);
        int i;
        notes.push_back('{ed, m, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout();
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m);
        apb(1'b0, a, 32'h0, ed, m, 1'b0);
    endtask
    task automatic wait_frame(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if (frame.valid === 1'b1) break;
        end
        if (i == lim) timeout();
    endtask
    // Sample strobe for one cycle; bad holds over, under, open, short
    task automatic put(input logic [1:0] ch, input logic [15:0] d, input logic ok,
                       input logic [3:0] bad);
        sample <= '{1'b1, ch, d, ok, bad[3], bad[2], bad[1], bad[0]};
        @(posedge pclk);
        sample.valid <= 1'b0;
        wait_frame(100);
        wait_frame(100);
    endtask
    function automatic logic [7:0] ca(input int ch, input int r);
        return `CDQ_A_CHBASE + 8'(ch * 16 + r * 4);
    endfunction
    // Float of n / 65536 for 0 < n < 2**24, exact in the mantissa
    function automatic logic [31:0] fl(input logic [31:0] n);
        int p;
        p = 0;
        for (int k = 0; k < 32; k++) begin
            if (n[k]) p = k;
        end
        return {1'b0, 8'(127 + p - 16), 23'(n << (23 - p))};
    endfunction
    // Watcher: each pready takes the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            cmp("prdata", notes[0].d & notes[0].m, prdata & notes[0].m);
            cmp("pslverr", {31'h0, notes[0].e}, {31'h0, pslverr});
            void'(notes.pop_front());
        end
    end
    // -----------------------------------------------
    // Main sequence
    // -----------------------------------------------
    initial begin
        logic [15:0] d;
        logic [31:0] e;
        logic [31:0] c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`CDQ_A_CTRL, 32'h0, 32'hFFFFFFFF);
        rd(`CDQ_A_RPI, {16'h0, `CDQ_RPI_RST}, 32'hFFFFFFFF);
        rd(`CDQ_A_MASK, 32'h0, 32'hFFFFFFFF);
        rd(ca(0, 1), `CDQ_SLOPE_ONE, 32'hFFFFFFFF);
        cmp("slope_cur", `CDQ_SLOPE_CUR, prdata_cur);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 8'h02, 32'h1, 32'h0, 32'h0, 1'b1);
        // Misaligned write into channel space must not land
        apb(1'b1, 8'h41, 32'h1, 32'h0, 32'h0, 1'b1);
        rd(ca(0, 0), 32'h0, 32'hFFFFFFFF);
        cmp("siglo_cur", {16'h0, `CDQ_SIGLO_CUR}, prdata_cur);
        wr(`CDQ_A_RPI, 32'h0);
        rd(`CDQ_A_RPI, 32'h1, 32'hFFFFFFFF);
        repeat (3) wait_frame(100);
        cmp("interval", 32'h1, {16'h0, delta});
        // Scaling: even channels at 1:1, odd ones offset and doubled
        for (int k = 0; k < 4; k++) begin
            d = 16'h0100 + (16'($random(seed)) & 16'h3FFF);
            e = {16'h0, d};
            if (k % 2 == 1) begin
                wr(ca(k, 0), 32'h100);
                wr(ca(k, 1), 32'h20000);
                wr(ca(k, 2), 32'h10000);
                e = 32'(d - 16'h0100) * 2 + 32'h10000;
            end
            put(2'(k), d, 1'b1, 4'h0);
            rd(ca(k, 3), fl(e), 32'hFFFFFFFF);
        end
        // Failed link check keeps ch3 data and raises the interrupt
        wr(`CDQ_A_MASK, 32'h4);
        put(2'h3, ~d, 1'b0, 4'h0);
        rd(ca(3, 3), fl(e), 32'hFFFFFFFF);
        rd(`CDQ_A_FLAGS, 32'h80, 32'h80);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(`CDQ_A_STAT, 32'h4);
        repeat (2) @(posedge pclk);
        cmp("irq", 32'h0, {31'h0, irq});
        put(2'h3, d, 1'b1, 4'h0);
        // Each range or wiring fault on ch2, then a clean sample
        for (int k = 0; k < 4; k++) begin
            put(2'h2, d, 1'b1, 4'(1 << k));
            rd(`CDQ_A_FLAGS, 32'h4, 32'h4);
            rd(`CDQ_A_STAT, 32'h2, 32'h2);
            cmp("fault_led", 32'h1, {31'h0, fault_led});
            put(2'h2, d, 1'b1, 4'h0);
            rd(`CDQ_A_FLAGS, 32'h0, 32'h4);
            cmp("fault_led", 32'h0, {31'h0, fault_led});
            // Clear the sticky bit so the next fault must set it again
            wr(`CDQ_A_STAT, 32'h2);
            rd(`CDQ_A_STAT, 32'h0, 32'h2);
        end
        // Calibrating, bad offset, uncalibrated on ch0
        for (int k = 0; k < 3; k++) begin
            wr(`CDQ_A_CAL, 32'h1 << (k * 4));
            repeat (2) wait_frame(100);
            rd(`CDQ_A_FLAGS, 32'h10, 32'h10);
            wr(`CDQ_A_CAL, 32'h0);
            repeat (2) wait_frame(100);
            rd(`CDQ_A_FLAGS, 32'h0, 32'h10);
        end
        // Sync pulse forces an early scan
        wr(`CDQ_A_RPI, 32'hA);
        wr(`CDQ_A_CTRL, 32'h2);
        wait_frame(100);
        repeat (5) @(posedge pclk);
        sync_pulse <= 1'b1;
        @(posedge pclk);
        sync_pulse <= 1'b0;
        wait_frame(4);
        // Output mode stamps only on converter load
        wr(`CDQ_A_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        c = count;
        repeat (40) @(posedge pclk);
        cmp("frames", c, count);
        dac_load <= 1'b1;
        @(posedge pclk);
        dac_load <= 1'b0;
        repeat (3) @(posedge pclk);
        cmp("frames", c + 32'h1, count);
        // Counter wrap while scanning every millisecond
        wr(`CDQ_A_CTRL, 32'h0);
        wr(`CDQ_A_RPI, 32'h1);
        for (int i = 0; i < 70000 && wrapped !== 1'b1; i++) @(posedge pclk);
        cmp("wrapped", 32'h1, {31'h0, wrapped});
        wait_frame(100);
        cmp("interval", 32'h1, {16'h0, delta});
        final_report();
    end
endmodule
